// [rtl/rss_pkg.sv]
package rss_pkg;

   // ==========================================================
   // Clock and timing
   localparam int CLK_FREQ_KHZ = 40000;
   localparam int RESET_PULSE_NS = 100;
   localparam int RESET_HOLD_CYCLES = (RESET_PULSE_NS * CLK_FREQ_KHZ + 999999) / 1000000;
   localparam int WDT_TICK_US = 1000;
   localparam int WDT_TICK_CYCLES = WDT_TICK_US * CLK_FREQ_KHZ / 1000;

   // ==========================================================
   // Watchdog timeout choices, in ticks
   localparam int WDT_SEL_W = 2;
   localparam int WDT_TO_TICKS_0 = 2;
   localparam int WDT_TO_TICKS_1 = 16;
   localparam int WDT_TO_TICKS_2 = 128;
   localparam int WDT_TO_TICKS_3 = 1024;

   // ==========================================================
   // Voltage monitor levels
   localparam int LV_THR_W = 4;
   localparam int LV_TRIP_BASE_MV = 1700;
   localparam int LV_TRIP_STEP_MV = 250;
   localparam int LV_TRIP_TOP_MV = 5450;
   localparam int HV_TRIP_MV = 5750;

   // ==========================================================
   // Interrupt indices
   localparam int IRQ_ALV = 0;
   localparam int IRQ_DLV = 1;
   localparam int IRQ_AHV = 2;
   localparam int IRQ_N = 3;

   // ==========================================================
   // Cause status field positions
   localparam int ST_PRECISE = 0;
   localparam int ST_EXTERNAL = 1;
   localparam int ST_SOFTWARE = 2;
   localparam int ST_WATCHDOG = 3;
   localparam int ST_ALV_RESET = 4;
   localparam int ST_DLV_RESET = 5;
   localparam int ST_ALV_IRQ = 6;
   localparam int ST_DLV_IRQ = 7;
   localparam int ST_AHV_IRQ = 8;
   localparam int ST_W = 9;

   // ==========================================================
   // Reset values
   localparam logic [ST_W-1:0] STATUS_RST = 9'h000;
   localparam logic WDT_EN_RST = 1'b0;

   // ==========================================================
   // Wake sequencing states
   typedef enum logic [1:0] {
      WK_IDLE = 2'b00,
      WK_WAIT = 2'b01,
      WK_SERVE = 2'b10
   } rss_wake_t;

endpackage

// [rtl/rss_reset_release.sv]
`timescale 1ns/100ps
module rss_reset_release #(
   parameter int HOLD = rss_pkg::RESET_HOLD_CYCLES
) (
   input wire logic core_clk_in,
   input wire logic rst_n_in,
   input wire logic src_in,
   output logic rst_n_out
);
   import rss_pkg::*;

   localparam int CW = $clog2(HOLD + 1);

   generate
      if (HOLD < 1) begin : g_chk
         $error("HOLD must be at least one cycle");
      end
   endgenerate

   typedef struct packed {
      logic [CW-1:0] cnt;
      logic rst_n;
   } rss_rel_state_t;

   rss_rel_state_t s;
   rss_rel_state_t next_s;

   // ==========================================================
   // Hold counter
   always_comb begin
      next_s = s;
      if (src_in) begin
         next_s.cnt = CW'(HOLD);
         next_s.rst_n = 1'b0;
      end else if (s.cnt != '0) begin
         next_s.cnt = s.cnt - CW'(1);
         next_s.rst_n = 1'b0;
      end else begin
         next_s.rst_n = 1'b1;
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         s.cnt <= CW'(HOLD);
         s.rst_n <= 1'b0;
      end else begin
         s <= next_s;
      end
   end

   assign rst_n_out = s.rst_n;

   // ==========================================================
   // Checks
   property p_fast_assert;
      @(posedge core_clk_in) disable iff (!rst_n_in) src_in |=> !rst_n_out;
   endproperty
   a_fast_assert: assert property (p_fast_assert) else $error("reset not asserted");

   property p_quiet_release;
      @(posedge core_clk_in) disable iff (!rst_n_in)
         $rose(rst_n_out) |-> $past(!src_in) && $past(!src_in, 2);
   endproperty
   a_quiet_release: assert property (p_quiet_release) else $error("early release");

endmodule // rss_reset_release

// [rtl/rss_watchdog.sv]
`timescale 1ns/100ps
module rss_watchdog #(
   parameter int TO_0 = rss_pkg::WDT_TO_TICKS_0,
   parameter int TO_1 = rss_pkg::WDT_TO_TICKS_1,
   parameter int TO_2 = rss_pkg::WDT_TO_TICKS_2,
   parameter int TO_3 = rss_pkg::WDT_TO_TICKS_3
) (
   input wire logic core_clk_in,
   input wire logic rst_n_in,
   input wire logic enable_in,
   input wire logic tick_in,
   input wire logic clear_in,
   input wire logic [rss_pkg::WDT_SEL_W-1:0] timeout_sel_in,
   output logic expire_out
);
   import rss_pkg::*;

   localparam int CW = $clog2(TO_3 + 1);

   generate
      if (TO_0 < 1 || TO_1 < TO_0 || TO_2 < TO_1 || TO_3 < TO_2) begin : g_chk
         $error("timeouts must be positive and ascending");
      end
   endgenerate

   function automatic logic [CW-1:0] limit(input logic [WDT_SEL_W-1:0] sel);
      case (sel)
         2'h0: limit = CW'(TO_0);
         2'h1: limit = CW'(TO_1);
         2'h2: limit = CW'(TO_2);
         default: limit = CW'(TO_3);
      endcase
   endfunction

   typedef struct packed {
      logic [CW-1:0] cnt;
      logic expire;
   } rss_wdt_state_t;

   rss_wdt_state_t s;
   rss_wdt_state_t next_s;

   // ==========================================================
   // Timeout counter
   always_comb begin
      next_s = s;
      next_s.expire = 1'b0;
      if (!enable_in || clear_in) begin
         next_s.cnt = '0;
      end else if (tick_in) begin
         if (s.cnt + CW'(1) >= limit(timeout_sel_in)) begin
            next_s.cnt = '0;
            next_s.expire = 1'b1;
         end else begin
            next_s.cnt = s.cnt + CW'(1);
         end
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign expire_out = s.expire;

   // ==========================================================
   // Checks
   property p_idle_quiet;
      @(posedge core_clk_in) disable iff (!rst_n_in) !enable_in |=> !expire_out;
   endproperty
   a_idle_quiet: assert property (p_idle_quiet) else $error("expire while disabled");

   property p_clear_holds;
      @(posedge core_clk_in) disable iff (!rst_n_in) clear_in |=> !expire_out;
   endproperty
   a_clear_holds: assert property (p_clear_holds) else $error("expire after clear");

endmodule // rss_watchdog

// [rtl/rss_supervisor.sv]
`timescale 1ns/100ps
module rss_supervisor #(
   parameter int WDT_TICK_CYCLES = rss_pkg::WDT_TICK_CYCLES,
   parameter int RESET_HOLD = rss_pkg::RESET_HOLD_CYCLES
) (
   input wire logic core_clk_in,
   input wire logic rst_n_in,
   input wire logic sleep_mode_in,
   input wire logic hibernate_mode_in,
   input wire logic buzz_active_in,
   input wire logic precise_digital_trip_in,
   input wire logic precise_analog_trip_in,
   input wire logic analog_regulator_en_in,
   input wire logic analog_lv_below_in,
   input wire logic digital_lv_below_in,
   input wire logic analog_hv_above_in,
   input wire logic [rss_pkg::LV_THR_W-1:0] analog_lv_threshold_in,
   input wire logic [rss_pkg::LV_THR_W-1:0] digital_lv_threshold_in,
   input wire logic analog_lv_reset_mode_in,
   input wire logic digital_lv_reset_mode_in,
   input wire logic [rss_pkg::IRQ_N-1:0] irq_clear_in,
   input wire logic external_reset_n_in,
   input wire logic software_reset_wr_in,
   input wire logic software_reset_wdata_in,
   input wire logic software_reset_disable_in,
   input wire logic wdt_enable_wr_in,
   input wire logic wdt_enable_wdata_in,
   input wire logic wdt_clear_in,
   input wire logic [rss_pkg::WDT_SEL_W-1:0] wdt_timeout_sel_in,
   output logic device_reset_n_out,
   output logic precise_digital_enable_out,
   output logic precise_analog_enable_out,
   output logic lv_monitor_enable_out,
   output logic [rss_pkg::LV_THR_W-1:0] analog_lv_threshold_out,
   output logic [rss_pkg::LV_THR_W-1:0] digital_lv_threshold_out,
   output logic analog_low_voltage_irq_out,
   output logic digital_low_voltage_irq_out,
   output logic analog_high_voltage_irq_out,
   output logic wake_request_out,
   output logic [rss_pkg::ST_W-1:0] reset_status_out,
   output logic wdt_enable_out
);
   import rss_pkg::*;

   localparam int TICK_W = $clog2(WDT_TICK_CYCLES);

   generate
      if (WDT_TICK_CYCLES < 2) begin : g_chk_tick
         $error("WDT_TICK_CYCLES must be at least two");
      end
      if (LV_TRIP_BASE_MV + LV_TRIP_STEP_MV * ((1 << LV_THR_W) - 1) != LV_TRIP_TOP_MV)
      begin : g_chk_thr
         $error("threshold code width does not cover the trip span");
      end
      if (HV_TRIP_MV <= LV_TRIP_TOP_MV) begin : g_chk_hv
         $error("high-voltage level must lie above the low-voltage span");
      end
   endgenerate

   // Monitors powered: never in hibernate, in sleep only while buzzed
   function automatic logic monitor_live(input logic sleep, input logic hib,
                                         input logic buzz);
      monitor_live = !hib && (!sleep || buzz);
   endfunction

   typedef struct packed {
      logic precise_dig_en;
      logic precise_ana_en;
      logic lv_mon_en;
      logic [LV_THR_W-1:0] alv_thr;
      logic [LV_THR_W-1:0] dlv_thr;
      logic [IRQ_N-1:0] pend;
      logic [IRQ_N-1:0] irq;
      rss_wake_t wake;
      logic wake_req;
      logic [ST_W-1:0] status;
      logic wdt_en;
      logic sw_hit;
      logic por_done;
      logic [TICK_W-1:0] tick_cnt;
      logic tick;
   } rss_core_state_t;

   rss_core_state_t s;
   rss_core_state_t next_s;

   logic dev_rst_n;
   logic wdt_expire;
   logic precise_trip;
   logic ext_active;
   logic alv_evt;
   logic dlv_evt;
   logic ahv_evt;
   logic alv_rst;
   logic dlv_rst;
   logic reset_src;
   logic awake;
   logic [IRQ_N-1:0] irq_evt;
   logic [ST_W-1:0] cause;

   // ==========================================================
   // Reset sources
   always_comb begin
      precise_trip = (precise_digital_trip_in && s.precise_dig_en) ||
                     (precise_analog_trip_in && s.precise_ana_en);
      ext_active = !external_reset_n_in;
      alv_evt = s.lv_mon_en && analog_lv_below_in;
      dlv_evt = s.lv_mon_en && digital_lv_below_in;
      ahv_evt = s.lv_mon_en && analog_hv_above_in;
      alv_rst = alv_evt && analog_lv_reset_mode_in;
      dlv_rst = dlv_evt && digital_lv_reset_mode_in;
      irq_evt = '0;
      irq_evt[IRQ_ALV] = alv_evt && !analog_lv_reset_mode_in;
      irq_evt[IRQ_DLV] = dlv_evt && !digital_lv_reset_mode_in;
      irq_evt[IRQ_AHV] = ahv_evt;
      reset_src = precise_trip || ext_active || s.sw_hit || wdt_expire ||
                  alv_rst || dlv_rst;
      cause = '0;
      cause[ST_PRECISE] = precise_trip;
      cause[ST_EXTERNAL] = ext_active;
      cause[ST_SOFTWARE] = s.sw_hit;
      cause[ST_WATCHDOG] = wdt_expire;
      cause[ST_ALV_RESET] = alv_rst;
      cause[ST_DLV_RESET] = dlv_rst;
      awake = !sleep_mode_in && !hibernate_mode_in;
   end

   // ==========================================================
   // Next state
   always_comb begin
      next_s = s;
      next_s.precise_dig_en = monitor_live(sleep_mode_in, hibernate_mode_in,
                                           buzz_active_in);
      next_s.precise_ana_en = monitor_live(sleep_mode_in, hibernate_mode_in,
                                           buzz_active_in) && analog_regulator_en_in;
      next_s.lv_mon_en = monitor_live(sleep_mode_in, hibernate_mode_in,
                                      buzz_active_in) && s.por_done;
      next_s.alv_thr = analog_lv_threshold_in;
      next_s.dlv_thr = digital_lv_threshold_in;
      next_s.por_done = s.por_done || dev_rst_n;
      next_s.sw_hit = software_reset_wr_in && software_reset_wdata_in &&
                      !software_reset_disable_in && dev_rst_n;
      if (wdt_enable_wr_in && wdt_enable_wdata_in) begin
         next_s.wdt_en = 1'b1;
      end
      next_s.tick = 1'b0;
      if (s.tick_cnt == TICK_W'(WDT_TICK_CYCLES - 1)) begin
         next_s.tick_cnt = '0;
         next_s.tick = 1'b1;
      end else begin
         next_s.tick_cnt = s.tick_cnt + TICK_W'(1);
      end
      if (|cause) begin
         next_s.status = cause;
      end else if (|irq_evt) begin
         next_s.status = '0;
         next_s.status[ST_ALV_IRQ] = irq_evt[IRQ_ALV];
         next_s.status[ST_DLV_IRQ] = irq_evt[IRQ_DLV];
         next_s.status[ST_AHV_IRQ] = irq_evt[IRQ_AHV];
      end
      next_s.pend = (s.pend & ~irq_clear_in) | irq_evt;
      case (s.wake)
         WK_IDLE: begin
            if ((|irq_evt) && !awake) begin
               next_s.wake = WK_WAIT;
            end
         end
         WK_WAIT: begin
            if (awake) begin
               next_s.wake = WK_SERVE;
            end
         end
         WK_SERVE: begin
            next_s.wake = WK_IDLE;
         end
         default: begin
            next_s.wake = WK_IDLE;
         end
      endcase
      next_s.wake_req = (next_s.wake == WK_WAIT);
      next_s.irq = next_s.pend & {IRQ_N{awake && (next_s.wake != WK_WAIT)}};
      if (!dev_rst_n) begin
         next_s.pend = '0;
         next_s.irq = '0;
         next_s.wake = WK_IDLE;
         next_s.wake_req = 1'b0;
         next_s.tick_cnt = '0;
         next_s.tick = 1'b0;
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         s <= '0;
         s.status <= STATUS_RST;
         s.wdt_en <= WDT_EN_RST;
      end else begin
         s <= next_s;
      end
   end

   // ==========================================================
   // Reset release and watchdog
   rss_reset_release #(
      .HOLD(RESET_HOLD)
   ) u_release (
      .core_clk_in(core_clk_in),
      .rst_n_in(rst_n_in),
      .src_in(reset_src),
      .rst_n_out(dev_rst_n)
   );

   rss_watchdog u_watchdog (
      .core_clk_in(core_clk_in),
      .rst_n_in(rst_n_in),
      .enable_in(s.wdt_en && dev_rst_n),
      .tick_in(s.tick),
      .clear_in(wdt_clear_in),
      .timeout_sel_in(wdt_timeout_sel_in),
      .expire_out(wdt_expire)
   );

   // ==========================================================
   // Outputs
   assign device_reset_n_out = dev_rst_n;
   assign precise_digital_enable_out = s.precise_dig_en;
   assign precise_analog_enable_out = s.precise_ana_en;
   assign lv_monitor_enable_out = s.lv_mon_en;
   assign analog_lv_threshold_out = s.alv_thr;
   assign digital_lv_threshold_out = s.dlv_thr;
   assign analog_low_voltage_irq_out = s.irq[IRQ_ALV];
   assign digital_low_voltage_irq_out = s.irq[IRQ_DLV];
   assign analog_high_voltage_irq_out = s.irq[IRQ_AHV];
   assign wake_request_out = s.wake_req;
   assign reset_status_out = s.status;
   assign wdt_enable_out = s.wdt_en;

   // ==========================================================
   // Checks
   property p_precise_reset;
      @(posedge core_clk_in) disable iff (!rst_n_in)
         (precise_digital_trip_in && precise_digital_enable_out) |=> !device_reset_n_out;
   endproperty
   a_precise_reset: assert property (p_precise_reset) else $error("no precise reset");

   property p_digital_on;
      @(posedge core_clk_in) disable iff (!rst_n_in)
         (!sleep_mode_in && !hibernate_mode_in) |=> precise_digital_enable_out;
   endproperty
   a_digital_on: assert property (p_digital_on) else $error("digital monitor off");

   property p_analog_follow;
      @(posedge core_clk_in) disable iff (!rst_n_in)
         !analog_regulator_en_in |=> !precise_analog_enable_out;
   endproperty
   a_analog_follow: assert property (p_analog_follow) else $error("analog part on");

   property p_hibernate_off;
      @(posedge core_clk_in) disable iff (!rst_n_in)
         hibernate_mode_in |=> !precise_digital_enable_out && !lv_monitor_enable_out;
   endproperty
   a_hibernate_off: assert property (p_hibernate_off) else $error("monitor on");

   property p_hv_flag;
      @(posedge core_clk_in) disable iff (!rst_n_in)
         (lv_monitor_enable_out && analog_hv_above_in && device_reset_n_out)
         |=> s.pend[IRQ_AHV] &&
             (reset_status_out[ST_AHV_IRQ] || (|reset_status_out[ST_DLV_RESET:ST_PRECISE]));
   endproperty
   a_hv_flag: assert property (p_hv_flag) else $error("high-voltage event lost");

   property p_lv_reset;
      @(posedge core_clk_in) disable iff (!rst_n_in)
         (lv_monitor_enable_out && analog_lv_below_in && analog_lv_reset_mode_in)
         |=> !device_reset_n_out && !$rose(s.pend[IRQ_ALV]);
   endproperty
   a_lv_reset: assert property (p_lv_reset) else $error("low-voltage reset missed");

   property p_monitors_wait;
      @(posedge core_clk_in) disable iff (!rst_n_in)
         !s.por_done |-> !lv_monitor_enable_out && (s.irq == '0);
   endproperty
   a_monitors_wait: assert property (p_monitors_wait) else $error("monitor early");

   sequence s_buzz_event;
      sleep_mode_in && lv_monitor_enable_out && analog_hv_above_in &&
      device_reset_n_out && (s.wake == WK_IDLE);
   endsequence

   sequence s_still_asleep;
      sleep_mode_in && device_reset_n_out;
   endsequence

   property p_wake_first;
      @(posedge core_clk_in) disable iff (!rst_n_in)
         s_buzz_event ##1 s_still_asleep |-> wake_request_out && !analog_high_voltage_irq_out;
   endproperty
   a_wake_first: assert property (p_wake_first) else $error("irq before wake");

   property p_external_hold;
      @(posedge core_clk_in) disable iff (!rst_n_in)
         !external_reset_n_in |=> !device_reset_n_out;
   endproperty
   a_external_hold: assert property (p_external_hold) else $error("external reset lost");

   property p_software_reset;
      @(posedge core_clk_in) disable iff (!rst_n_in)
         (software_reset_wr_in && software_reset_wdata_in && !software_reset_disable_in &&
          device_reset_n_out) |-> ##2 !device_reset_n_out;
   endproperty
   a_software_reset: assert property (p_software_reset) else $error("no software reset");

   property p_software_blocked;
      @(posedge core_clk_in) disable iff (!rst_n_in)
         s.sw_hit |-> $past(!software_reset_disable_in);
   endproperty
   a_software_blocked: assert property (p_software_blocked) else $error("disable ignored");

   property p_wdt_starts_off;
      @(posedge core_clk_in) disable iff (!rst_n_in)
         $rose(rst_n_in) |-> !wdt_enable_out && (reset_status_out == STATUS_RST);
   endproperty
   a_wdt_starts_off: assert property (p_wdt_starts_off) else $error("bad power-on state");

   property p_wdt_sticky;
      @(posedge core_clk_in) disable iff (!rst_n_in) wdt_enable_out |=> wdt_enable_out;
   endproperty
   a_wdt_sticky: assert property (p_wdt_sticky) else $error("watchdog enable cleared");

   property p_wdt_reset;
      @(posedge core_clk_in) disable iff (!rst_n_in)
         wdt_expire |=> !device_reset_n_out && reset_status_out[ST_WATCHDOG];
   endproperty
   a_wdt_reset: assert property (p_wdt_reset) else $error("watchdog reset missed");

endmodule // rss_supervisor

// [verif/rss_fw_model.sv]
`timescale 1ns/100ps
module rss_fw_model (
   input wire logic core_clk_in,
   input wire logic rst_n_in,
   input wire logic hold_reset_in,
   input wire logic kick_en_in,
   output logic external_reset_n_out,
   output logic wdt_clear_out
);
   logic [1:0] kick_cnt;
   // ==========================================
   // Reset pin and periodic kick
   always_ff @(posedge core_clk_in) begin
      external_reset_n_out <= !hold_reset_in;
      if (!rst_n_in) begin
         kick_cnt <= 2'h0;
         wdt_clear_out <= 1'b0;
      end else begin
         kick_cnt <= kick_cnt + 2'h1;
         wdt_clear_out <= kick_en_in && (kick_cnt == 2'h0);
      end
   end
endmodule // rss_fw_model

// [verif/testbench.sv]
`timescale 1ns/100ps
module testbench;
   import rss_pkg::*;
   logic core_clk_in, rst_n_in, sleep_mode_in, hibernate_mode_in, buzz_active_in;
   logic precise_digital_trip_in, precise_analog_trip_in, analog_regulator_en_in;
   logic analog_lv_below_in, digital_lv_below_in, analog_hv_above_in;
   logic [LV_THR_W-1:0] analog_lv_threshold_in, digital_lv_threshold_in;
   logic [LV_THR_W-1:0] analog_lv_threshold_out, digital_lv_threshold_out;
   logic analog_lv_reset_mode_in, digital_lv_reset_mode_in, external_reset_n_in;
   logic [IRQ_N-1:0] irq_clear_in;
   logic software_reset_wr_in, software_reset_wdata_in, software_reset_disable_in;
   logic wdt_enable_wr_in, wdt_enable_wdata_in, wdt_clear_in;
   logic [WDT_SEL_W-1:0] wdt_timeout_sel_in;
   logic device_reset_n_out, precise_digital_enable_out, precise_analog_enable_out;
   logic lv_monitor_enable_out, analog_low_voltage_irq_out, digital_low_voltage_irq_out;
   logic analog_high_voltage_irq_out, wake_request_out, wdt_enable_out;
   logic [ST_W-1:0] reset_status_out;
   logic hold_reset, kick_en;
   int errors, check_count, wait_n;
   localparam int SIM_TICK = 8;
   rss_supervisor #(.WDT_TICK_CYCLES(SIM_TICK), .RESET_HOLD(RESET_HOLD_CYCLES)) dut (.*);
   rss_fw_model fw (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
      .hold_reset_in(hold_reset), .kick_en_in(kick_en),
      .external_reset_n_out(external_reset_n_in), .wdt_clear_out(wdt_clear_in));
   always #12.5 core_clk_in = ~core_clk_in;
   // ==========================================
   // Tasks
   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk_in);
      #1;
   endtask
   task automatic chk(input string what, input logic [ST_W-1:0] exp, input logic [ST_W-1:0] got);
      check_count++;
      if (got !== exp) begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wait_rel(input string what);
      int i;
      i = 0;
      while (device_reset_n_out !== 1'b1 && i < 40) begin
         cyc(1);
         i++;
      end
      chk("release", 9'h001, 9'(device_reset_n_out));
      $display("test %s done", what);
   endtask
   task automatic finish_test;
      $display("checks %0d mismatches %0d", check_count, errors);
      if (errors == 0 && check_count > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   // ==========================================
   // Tests
   initial begin
      {core_clk_in, rst_n_in, sleep_mode_in, hibernate_mode_in, buzz_active_in} = 5'h00;
      {precise_digital_trip_in, precise_analog_trip_in, digital_lv_below_in} = 3'h0;
      {analog_lv_below_in, analog_lv_reset_mode_in, digital_lv_reset_mode_in} = 3'h0;
      {software_reset_wr_in, software_reset_wdata_in, software_reset_disable_in} = 3'h0;
      {wdt_enable_wr_in, wdt_enable_wdata_in, hold_reset, kick_en} = 4'h0;
      {analog_regulator_en_in, analog_hv_above_in} = 2'h3;
      {analog_lv_threshold_in, digital_lv_threshold_in} = 8'h00;
      irq_clear_in = 3'h0;
      wdt_timeout_sel_in = 2'h0;
      cyc(16);
      chk("monitor off", 9'h000, {7'h00, lv_monitor_enable_out, analog_high_voltage_irq_out});
      analog_hv_above_in = 1'b0;
      rst_n_in = 1'b1;
      wait_rel("power up");
      cyc(2);
      chk("wdt off", 9'h000, 9'(wdt_enable_out));
      chk("status", 9'h000, reset_status_out);
      chk("enables", 9'h007, {6'h00, precise_digital_enable_out, precise_analog_enable_out,
         lv_monitor_enable_out});
      for (int t = 0; t < 16; t++) begin
         analog_lv_threshold_in = 4'(t);
         digital_lv_threshold_in = 4'(15 - t);
         cyc(1);
         chk("thr", 9'(t * 16 + 15 - t), {1'b0, analog_lv_threshold_out, digital_lv_threshold_out});
      end
      analog_regulator_en_in = 1'b0;
      cyc(2);
      chk("analog precise", 9'h002, {7'h00, precise_digital_enable_out,
         precise_analog_enable_out});
      precise_analog_trip_in = 1'b1;
      cyc(2);
      chk("analog trip off", 9'h001, 9'(device_reset_n_out));
      analog_regulator_en_in = 1'b1;
      precise_digital_trip_in = 1'b1;
      cyc(2);
      chk("precise rst", 9'h000, 9'(device_reset_n_out));
      {precise_digital_trip_in, precise_analog_trip_in} = 2'h0;
      wait_rel("precise");
      chk("status", 9'h001, reset_status_out);
      for (int m = 0; m < 2; m++) begin
         hibernate_mode_in = 1'(m);
         hold_reset = 1'b1;
         cyc(8);
         chk("ext rst", 9'h000, 9'(device_reset_n_out));
         hold_reset = 1'b0;
         hibernate_mode_in = 1'b0;
         wait_rel("external");
         chk("status", 9'h002, reset_status_out);
      end
      {software_reset_disable_in, software_reset_wr_in, software_reset_wdata_in} = 3'h7;
      cyc(1);
      software_reset_wr_in = 1'b0;
      cyc(4);
      chk("sw blocked", 9'h001, 9'(device_reset_n_out));
      {software_reset_disable_in, software_reset_wr_in} = 2'h1;
      cyc(1);
      software_reset_wr_in = 1'b0;
      cyc(2);
      chk("sw rst", 9'h000, 9'(device_reset_n_out));
      wait_rel("software");
      chk("status", 9'h004, reset_status_out);
      for (int m = 0; m < 2; m++) begin
         for (int r = 0; r < 2; r++) begin
            {analog_lv_reset_mode_in, digital_lv_reset_mode_in} = {1'(r), 1'(r)};
            {digital_lv_below_in, analog_lv_below_in} = 2'(1 << m);
            cyc(3);
            chk("lv irq", 9'(r == 0), 9'(m ? digital_low_voltage_irq_out
               : analog_low_voltage_irq_out));
            {digital_lv_below_in, analog_lv_below_in} = 2'h0;
            irq_clear_in = 3'h3;
            cyc(1);
            irq_clear_in = 3'h0;
            wait_rel("low voltage");
            chk("status", (r ? 9'h010 : 9'h040) << m, reset_status_out);
         end
      end
      {sleep_mode_in, buzz_active_in} = 2'h2;
      cyc(2);
      chk("sleep off", 9'h000, {7'h00, precise_digital_enable_out, lv_monitor_enable_out});
      {buzz_active_in, analog_hv_above_in} = 2'h3;
      cyc(3);
      chk("buzz on", 9'h001, 9'(precise_digital_enable_out));
      chk("wake", 9'h002, {7'h00, wake_request_out, analog_high_voltage_irq_out});
      {sleep_mode_in, buzz_active_in} = 2'h0;
      cyc(3);
      chk("woke irq", 9'h001, {7'h00, wake_request_out, analog_high_voltage_irq_out});
      chk("status", 9'h100, reset_status_out);
      analog_hv_above_in = 1'b0;
      irq_clear_in = 3'h4;
      cyc(1);
      irq_clear_in = 3'h0;
      cyc(1);
      chk("hv clear", 9'h000, 9'(analog_high_voltage_irq_out));
      $display("test monitors done");
      {wdt_enable_wr_in, wdt_enable_wdata_in, kick_en} = 3'h7;
      cyc(1);
      wdt_enable_wdata_in = 1'b0;
      cyc(1);
      wdt_enable_wr_in = 1'b0;
      cyc(60);
      chk("kicked", 9'h003, {7'h00, wdt_enable_out, device_reset_n_out});
      kick_en = 1'b0;
      for (int i = 0; i < 40 && device_reset_n_out === 1'b1; i++) cyc(1);
      chk("wdt rst", 9'h000, 9'(device_reset_n_out));
      kick_en = 1'b1;
      wait_rel("watchdog");
      chk("status", 9'h008, reset_status_out);
      chk("wdt kept", 9'h001, 9'(wdt_enable_out));
      wdt_timeout_sel_in = 2'h1;
      kick_en = 1'b0;
      wait_n = 0;
      while (device_reset_n_out === 1'b1 && wait_n < 200) begin
         cyc(1);
         wait_n++;
      end
      chk("wdt span", 9'h001, 9'(wait_n > (WDT_TO_TICKS_1 - 1) * SIM_TICK &&
         wait_n <= (WDT_TO_TICKS_1 + 1) * SIM_TICK + 2));
      rst_n_in = 1'b0;
      cyc(2);
      chk("por clear", 9'h000, {wdt_enable_out, reset_status_out[7:0]});
      finish_test();
   end
   initial begin
      #(25 * 4000);
      errors++;
      finish_test();
   end
endmodule // testbench
